// file: link_cfg_pkg.sv
// constants and carrier types for the link configuration register bank
package link_cfg_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register offsets, reset values and write masks
   localparam logic [7:0] MISC_CFG_ADDR = 8'h03;
   localparam logic [7:0] TIMEOUT_CTL_ADDR = 8'h04;
   localparam logic [7:0] FWD_FILT_ADDR = 8'h05;
   localparam logic [7:0] MISC_CFG_RESET = 8'hF0;
   localparam logic [7:0] TIMEOUT_CTL_RESET = 8'hFE;
   localparam logic [7:0] FWD_FILT_RESET = 8'h1E;
   localparam logic [7:0] MISC_CFG_WMASK = 8'hFE;
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CRC_GEN_BIT = 6;
   localparam int PULL_DIR_BIT = 5;
   localparam int SYNC_FILT_BIT = 4;
   localparam int FWD_MATCH_BIT = 3;
   localparam int AUTO_ACK_BIT = 2;
   localparam int GATE_BIT = 1;
   localparam int TIMEOUT_LSB = 1;
   localparam int TIMEOUT_OFF_BIT = 0;
   localparam int FWD_ALL_BIT = 7;
   localparam int HOLD_LSB = 4;
   localparam int DEPTH_LSB = 0;
   localparam int TIMEOUT_W = 7;
   localparam int HOLD_W = 3;
   localparam int DEPTH_W = 4;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_PERIOD_PS = 25_000;
   localparam int WDOG_UNIT_MS = 2;
   localparam int WDOG_UNIT_CYCLES = WDOG_UNIT_MS * (CLK_HZ / 1000);
   localparam int HOLD_UNIT_NS = 50;
   localparam int HOLD_UNIT_CYCLES =
      (HOLD_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HOLD_TAPS = ((1 << HOLD_W) - 1) * HOLD_UNIT_CYCLES;
   localparam int GLITCH_UNIT_NS = 5;
   localparam int GLITCH_UNIT_PS = GLITCH_UNIT_NS * 1000;
   localparam logic [2:0] SYNC_FILT_CYCLES = 3'h2;
   localparam logic [2:0] HSYNC_DUAL_CYCLES = 3'h4;
   localparam logic [2:0] NO_FILT_CYCLES = 3'h1;
   localparam int NUM_FILT = 5;
   localparam int PIXEL_W = 24;

   ////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic data_valid;
      logic hsync;
      logic vsync;
   } sync_bundle_t;

   typedef enum logic [2:0] {
      WD_IDLE = 3'b001,
      WD_RUN = 3'b010,
      WD_EXPIRED = 3'b100
   } wdog_state_t;

endpackage

// file: link_ctrl_config_regs.sv
// link configuration registers and the filters, gating and watchdog
`timescale 1ns/1ps

// Operation
// (RULE1) misc config bit 6 enables back-channel CRC generation; resets to 1.
// (RULE2) pull-direction bit: 1 pulls undriven inputs down, 0 up; resets to 1.
// (RULE3) filter bit rejects sync and data_valid pulses under two clocks.
// (RULE4) hsync filter is two cycles single-lane, four cycles dual-lane.
// (RULE5) match bit forwards local I2C transactions on address match only.
// (RULE6) auto-ack bit acknowledges writes regardless of forward link lock.
// (RULE7) protected partner: pixels always gated, gate bit ignored.
// (RULE8) unprotected partner: gate bit 1 gates pixels, 0 passes.
// (RULE9) watchdog ends control transactions after timeout field times 2 ms.
// (RULE10) software must not program the timeout field to zero.
// (RULE11) timeout-off bit stops the watchdog; resets to 0.
// (RULE12) forward-all bit forwards every local I2C transaction across link.
// (RULE13) SDA input held for hold field times 50 ns relative to SCL; sda_held_out lags scl_filt_out by one further 25 ns clock.
// (RULE14) SCL and SDA glitches up to depth field times 5 ns rejected.
// (RULE15) back channel stays on unless enable and both forward bits are 0.
// (RULE16) reserved bit 0 of misc config ignores writes, reads zero.
module link_ctrl_config_regs
   import link_cfg_pkg::*;
#(
   parameter int WDOG_UNIT_CLKS = WDOG_UNIT_CYCLES
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire reg_req_t reg_req_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [7:0] reg_raddr_in,
   input wire sync_bundle_t sync_in,
   output sync_bundle_t sync_out,
   input wire logic dual_lane_in,
   input wire logic [PIXEL_W-1:0] pixel_in,
   output logic [PIXEL_W-1:0] pixel_out,
   input wire logic protected_partner_in,
   input wire logic i2c_txn_start_in,
   input wire logic i2c_addr_match_in,
   output logic i2c_forward_out,
   input wire logic i2c_wr_req_in,
   input wire logic fwd_lock_in,
   output logic i2c_wr_ack_out,
   input wire logic cc_txn_busy_in,
   output logic cc_txn_abort_out,
   input wire logic backchan_on_in,
   output logic backchan_active_out,
   output logic backchan_crc_gen_on_out,
   output logic undriven_input_pull_dir_out,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_filt_out,
   output logic sda_held_out
);

   ////////////////////////////////////////////////////////////////////////
   // register bank
   logic [7:0] misc_cfg_r, misc_cfg_nxt;
   logic [7:0] timeout_ctl_r, timeout_ctl_nxt;
   logic [7:0] fwd_filt_r, fwd_filt_nxt;
   logic [7:0] rdata_nxt;

   // writes land next edge; unmapped writes are dropped
   always_comb begin
      misc_cfg_nxt = misc_cfg_r;
      timeout_ctl_nxt = timeout_ctl_r;
      fwd_filt_nxt = fwd_filt_r;
      if (reg_req_in.wr) begin
         case (reg_req_in.addr)
            MISC_CFG_ADDR: begin
               misc_cfg_nxt = reg_req_in.wdata & MISC_CFG_WMASK; // [RULE16]
            end
            TIMEOUT_CTL_ADDR: begin
               timeout_ctl_nxt = reg_req_in.wdata;
            end
            FWD_FILT_ADDR: begin
               fwd_filt_nxt = reg_req_in.wdata;
            end
            default: begin
               misc_cfg_nxt = misc_cfg_r;
            end
         endcase
      end
   end

   // read data registered one cycle after the address
   always_comb begin
      case (reg_raddr_in)
         MISC_CFG_ADDR: rdata_nxt = misc_cfg_r & MISC_CFG_WMASK; // [RULE16]
         TIMEOUT_CTL_ADDR: rdata_nxt = timeout_ctl_r;
         FWD_FILT_ADDR: rdata_nxt = fwd_filt_r;
         default: rdata_nxt = UNMAPPED_RDATA;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         misc_cfg_r <= MISC_CFG_RESET; // [RULE1] [RULE2]
         timeout_ctl_r <= TIMEOUT_CTL_RESET; // [RULE9] [RULE11]
         fwd_filt_r <= FWD_FILT_RESET; // [RULE13] [RULE14]
         reg_rdata_out <= UNMAPPED_RDATA;
      end else begin
         misc_cfg_r <= misc_cfg_nxt;
         timeout_ctl_r <= timeout_ctl_nxt;
         fwd_filt_r <= fwd_filt_nxt;
         reg_rdata_out <= rdata_nxt;
      end
   end

   // field views
   logic fwd_match_en, fwd_all_en, gate_en;
   logic [TIMEOUT_W-1:0] ctrl_chan_timeout_count;
   logic ctrl_chan_timeout_off;
   logic [HOLD_W-1:0] hold_units;
   logic [DEPTH_W-1:0] filt_depth;
   assign fwd_match_en = misc_cfg_r[FWD_MATCH_BIT];
   assign fwd_all_en = fwd_filt_r[FWD_ALL_BIT];
   assign gate_en = misc_cfg_r[GATE_BIT];
   assign ctrl_chan_timeout_count =
      timeout_ctl_r[TIMEOUT_LSB +: TIMEOUT_W];
   assign ctrl_chan_timeout_off = timeout_ctl_r[TIMEOUT_OFF_BIT];
   assign hold_units = fwd_filt_r[HOLD_LSB +: HOLD_W];
   assign filt_depth = fwd_filt_r[DEPTH_LSB +: DEPTH_W];

   ////////////////////////////////////////////////////////////////////////
   // static controls and I2C forwarding decisions
   logic fwd_nxt, ack_nxt, bc_nxt;

   // any forwarding mode keeps the back channel alive for the answers
   always_comb begin
      fwd_nxt = i2c_txn_start_in &
         (fwd_all_en | (fwd_match_en & i2c_addr_match_in)); // [RULE5] [RULE12]
      ack_nxt = i2c_wr_req_in &
         (misc_cfg_r[AUTO_ACK_BIT] | fwd_lock_in); // [RULE6]
      bc_nxt = backchan_on_in | fwd_match_en | fwd_all_en; // [RULE15]
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         i2c_forward_out <= 1'b0;
         i2c_wr_ack_out <= 1'b0;
         backchan_active_out <= 1'b1;
         backchan_crc_gen_on_out <= MISC_CFG_RESET[CRC_GEN_BIT];
         undriven_input_pull_dir_out <= MISC_CFG_RESET[PULL_DIR_BIT];
      end else begin
         i2c_forward_out <= fwd_nxt;
         i2c_wr_ack_out <= ack_nxt;
         backchan_active_out <= bc_nxt;
         backchan_crc_gen_on_out <= misc_cfg_r[CRC_GEN_BIT]; // [RULE1]
         undriven_input_pull_dir_out <= misc_cfg_r[PULL_DIR_BIT]; // [RULE2]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pulse filters: sync lines 0..2, scl 3, sda 4
   logic [NUM_FILT-1:0] filt_raw, filt_q;
   logic [2:0] filt_thr [NUM_FILT];
   logic [2:0] glitch_thr;

   assign filt_raw = {sda_in, scl_in, sync_in.data_valid,
                      sync_in.hsync, sync_in.vsync};

   // a glitch of depth*5ns is rejected by needing one cycle more than it
   always_comb begin
      glitch_thr = 3'((int'(filt_depth) * GLITCH_UNIT_PS)
                      / CLK_PERIOD_PS + 1); // [RULE14]
      filt_thr[0] = misc_cfg_r[SYNC_FILT_BIT] ?
         SYNC_FILT_CYCLES : NO_FILT_CYCLES; // [RULE3]
      filt_thr[1] = !misc_cfg_r[SYNC_FILT_BIT] ? NO_FILT_CYCLES :
         (dual_lane_in ? HSYNC_DUAL_CYCLES : SYNC_FILT_CYCLES); // [RULE4]
      filt_thr[2] = filt_thr[0];
      filt_thr[3] = glitch_thr;
      filt_thr[4] = glitch_thr;
   end

   // output follows the input only once it has held thr cycles
   genvar gi;
   generate
      for (gi = 0; gi < NUM_FILT; gi++) begin : g_filt
         logic [2:0] cnt_r, cnt_nxt;
         logic q_r, q_nxt;
         // lane keeps its own flop so the shared vector has one driver a bit
         assign filt_q[gi] = q_r;
         always_comb begin
            cnt_nxt = 3'h0;
            q_nxt = q_r;
            if (filt_raw[gi] != q_r) begin
               if (cnt_r + 3'h1 >= filt_thr[gi]) begin
                  q_nxt = filt_raw[gi]; // [RULE3] [RULE14]
               end else begin
                  cnt_nxt = cnt_r + 3'h1;
               end
            end
         end
         always_ff @(posedge mclk_in) begin
            if (!reset_n_in) begin
               cnt_r <= 3'h0;
               q_r <= 1'b0;
            end else begin
               cnt_r <= cnt_nxt;
               q_r <= q_nxt;
            end
         end
      end
   endgenerate

   assign sync_out.vsync = filt_q[0];
   assign sync_out.hsync = filt_q[1];
   assign sync_out.data_valid = filt_q[2];
   assign scl_filt_out = filt_q[3];

   ////////////////////////////////////////////////////////////////////////
   // sda hold delay line behind the glitch filter
   logic [HOLD_TAPS-1:0] hold_sr_r, hold_sr_nxt;
   logic sda_hold_nxt;
   int hold_tap;

   // delay in whole cycles, 50 ns rounded up to the clock
   always_comb begin
      hold_tap = int'(hold_units) * HOLD_UNIT_CYCLES;
      hold_sr_nxt = {hold_sr_r[HOLD_TAPS-2:0], filt_q[4]};
      if (hold_tap == 0) begin
         sda_hold_nxt = filt_q[4];
      end else begin
         sda_hold_nxt = hold_sr_r[hold_tap-1]; // [RULE13]
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         hold_sr_r <= '0;
         sda_held_out <= 1'b0;
      end else begin
         hold_sr_r <= hold_sr_nxt;
         sda_held_out <= sda_hold_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pixel gating by data_valid
   logic [PIXEL_W-1:0] pixel_nxt;
   logic gate_now;

   // a protected partner forces gating so clear data never leaks
   always_comb begin
      gate_now = protected_partner_in | gate_en; // [RULE7] [RULE8]
      pixel_nxt = pixel_in;
      if (gate_now && !sync_in.data_valid) begin
         pixel_nxt = '0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         pixel_out <= '0;
      end else begin
         pixel_out <= pixel_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control-channel watchdog
   wdog_state_t wd_state_r, wd_state_nxt;
   logic [16:0] tick_r, tick_nxt;
   logic [TIMEOUT_W-1:0] units_r, units_nxt;
   logic abort_nxt;

   // a zero field expires after one unit; software must avoid it [RULE10]
   always_comb begin
      wd_state_nxt = wd_state_r;
      tick_nxt = tick_r;
      units_nxt = units_r;
      abort_nxt = 1'b0;
      case (wd_state_r)
         WD_IDLE: begin
            tick_nxt = 17'h0;
            units_nxt = '0;
            if (cc_txn_busy_in && !ctrl_chan_timeout_off) begin
               wd_state_nxt = WD_RUN; // [RULE11]
            end
         end
         WD_RUN: begin
            if (!cc_txn_busy_in || ctrl_chan_timeout_off) begin
               wd_state_nxt = WD_IDLE; // [RULE11]
            end else if (tick_r == 17'(WDOG_UNIT_CLKS - 1)) begin
               tick_nxt = 17'h0;
               units_nxt = units_r + 7'h01;
               if (units_r + 7'h01 >= ctrl_chan_timeout_count) begin
                  abort_nxt = 1'b1; // [RULE9]
                  wd_state_nxt = WD_EXPIRED;
               end
            end else begin
               tick_nxt = tick_r + 17'h1;
            end
         end
         WD_EXPIRED: begin
            // wait for the aborted transaction to drop before rearming
            if (!cc_txn_busy_in) begin
               wd_state_nxt = WD_IDLE;
            end
         end
         default: begin
            wd_state_nxt = WD_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         wd_state_r <= WD_IDLE;
         tick_r <= 17'h0;
         units_r <= '0;
         cc_txn_abort_out <= 1'b0;
      end else begin
         wd_state_r <= wd_state_nxt;
         tick_r <= tick_nxt;
         units_r <= units_nxt;
         cc_txn_abort_out <= abort_nxt;
      end
   end

endmodule // link_ctrl_config_regs

// file: link_cfg_monitor.sv
// assertion checker for the link configuration register bank
`timescale 1ns/1ps
module link_cfg_monitor
   import link_cfg_pkg::*;
#(
   parameter int WDOG_UNIT_CLKS = WDOG_UNIT_CYCLES
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire reg_req_t reg_req_in,
   input wire logic [7:0] reg_raddr_in,
   input wire logic [7:0] reg_rdata_out,
   input wire sync_bundle_t sync_in,
   input wire sync_bundle_t sync_out,
   input wire logic [PIXEL_W-1:0] pixel_in,
   input wire logic [PIXEL_W-1:0] pixel_out,
   input wire logic protected_partner_in,
   input wire logic i2c_txn_start_in,
   input wire logic i2c_addr_match_in,
   input wire logic i2c_forward_out,
   input wire logic i2c_wr_req_in,
   input wire logic fwd_lock_in,
   input wire logic i2c_wr_ack_out,
   input wire logic cc_txn_busy_in,
   input wire logic cc_txn_abort_out,
   input wire logic backchan_on_in,
   input wire logic backchan_active_out,
   input wire logic backchan_crc_gen_on_out
);
   logic [7:0] m_r, t_r, f_r, m_nxt, t_nxt, f_nxt, rd_exp;
   logic [23:0] wd_r, wd_nxt;

   ////////////////////////////////////////////////////////////////////////
   // shadow registers rebuilt from the write port alone
   always_comb begin
      m_nxt = m_r;
      t_nxt = t_r;
      f_nxt = f_r;
      if (reg_req_in.wr && reg_req_in.addr == 8'h03)
         m_nxt = reg_req_in.wdata & 8'hFE;
      if (reg_req_in.wr && reg_req_in.addr == 8'h04)
         t_nxt = reg_req_in.wdata;
      if (reg_req_in.wr && reg_req_in.addr == 8'h05)
         f_nxt = reg_req_in.wdata;
      // busy cycles seen while the watchdog is allowed to run
      wd_nxt = (cc_txn_busy_in && !t_r[0]) ? wd_r + 24'h1 : 24'h0;
      case (reg_raddr_in)
         8'h03: rd_exp = m_r;
         8'h04: rd_exp = t_r;
         8'h05: rd_exp = f_r;
         default: rd_exp = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      m_r <= reset_n_in ? m_nxt : 8'hF0;
      t_r <= reset_n_in ? t_nxt : 8'hFE;
      f_r <= reset_n_in ? f_nxt : 8'h1E;
      wd_r <= reset_n_in ? wd_nxt : 24'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);

   property p_rd;
      $past(reset_n_in) |-> reg_rdata_out == $past(rd_exp);
   endproperty
   a_rd: assert property (p_rd) else $error("read data wrong");
   property p_crc;
      $past(reset_n_in) && $stable(m_r[CRC_GEN_BIT])
         |-> backchan_crc_gen_on_out == m_r[CRC_GEN_BIT];
   endproperty
   a_crc: assert property (p_crc) else $error("crc enable wrong");
   property p_bc;
      $past(reset_n_in) |-> backchan_active_out ==
         $past(backchan_on_in | m_r[FWD_MATCH_BIT] | f_r[FWD_ALL_BIT]);
   endproperty
   a_bc: assert property (p_bc) else $error("back channel wrong");
   property p_fwd;
      $past(reset_n_in) |-> i2c_forward_out == $past(i2c_txn_start_in &&
         (f_r[FWD_ALL_BIT] || m_r[FWD_MATCH_BIT] && i2c_addr_match_in));
   endproperty
   a_fwd: assert property (p_fwd)
      else $error("forward wrong");
   property p_ack;
      $past(reset_n_in) |-> i2c_wr_ack_out ==
         $past(i2c_wr_req_in && (m_r[AUTO_ACK_BIT] || fwd_lock_in));
   endproperty
   a_ack: assert property (p_ack) else $error("write ack wrong");
   property p_gate;
      $past(reset_n_in) |-> pixel_out == ($past((protected_partner_in
         | m_r[GATE_BIT]) && !sync_in.data_valid) ? '0 : $past(pixel_in));
   endproperty
   a_gate: assert property (p_gate)
      else $error("gating wrong");
   property p_filt;
      $rose(sync_out.vsync) && m_r[SYNC_FILT_BIT]
         |-> $past(sync_in.vsync, 1) && $past(sync_in.vsync, 2);
   endproperty
   a_filt: assert property (p_filt)
      else $error("short pulse passed");
   property p_wd;
      cc_txn_abort_out |-> wd_r >= t_r[7:1] * WDOG_UNIT_CLKS
         && wd_r <= t_r[7:1] * WDOG_UNIT_CLKS + 2;
   endproperty
   a_wd: assert property (p_wd)
      else $error("abort mistimed");
endmodule // link_cfg_monitor

bind link_ctrl_config_regs link_cfg_monitor
   #(.WDOG_UNIT_CLKS(WDOG_UNIT_CLKS)) mon (.*);

// file: link_far_end.sv
// far-end model: remote serializer serving control-channel transactions
`timescale 1ns/1ps
module link_far_end (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic go_in,
   input wire logic [7:0] lat_in,
   input wire logic abort_in,
   output logic busy_out
);
   logic [7:0] cnt_r;

   // a transaction stays in flight lat_in plus one cycles unless cut off
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in || abort_in) begin
         busy_out <= 1'b0;
         cnt_r <= 8'h00;
      end else if (go_in && !busy_out) begin
         busy_out <= 1'b1;
         cnt_r <= lat_in;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end else begin
         busy_out <= 1'b0;
      end
   end
endmodule // link_far_end

// file: tb.sv
// self-checking bench for the link configuration register bank
`timescale 1ns/1ps
module tb;
   import link_cfg_pkg::*;
   localparam int UNIT = 4;
   logic mclk_in = 1'b0, reset_n_in = 1'b0, go = 1'b0;
   reg_req_t reg_req_in = '0;
   logic [7:0] reg_raddr_in = 8'h00, reg_rdata_out, lat = 8'h00;
   logic [4:0] raw = 5'h00; // data_valid, hsync, vsync, scl, sda
   sync_bundle_t sync_in, sync_out;
   logic scl_in, sda_in, scl_filt_out, sda_held_out, dual_lane_in = 1'b0;
   logic [PIXEL_W-1:0] pixel_in = '0, pixel_out;
   logic protected_partner_in = 1'b0, i2c_txn_start_in = 1'b0;
   logic i2c_addr_match_in = 1'b0, i2c_wr_req_in = 1'b0, fwd_lock_in = 1'b0;
   logic i2c_forward_out, i2c_wr_ack_out, cc_txn_busy_in, cc_txn_abort_out;
   logic backchan_on_in = 1'b1, backchan_active_out, backchan_crc_gen_on_out;
   logic undriven_input_pull_dir_out;
   logic [7:0] regs [3:5];
   int n_fail = 0, n_compared = 0, cyc = 0, t1;
   wire [4:0] filt = {sync_out, scl_filt_out, sda_held_out};
   assign {sync_in, scl_in, sda_in} = raw;

   link_ctrl_config_regs #(.WDOG_UNIT_CLKS(UNIT)) uut (.*);
   link_far_end far (.mclk_in, .reset_n_in, .go_in(go), .lat_in(lat),
      .abort_in(cc_txn_abort_out), .busy_out(cc_txn_busy_in));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #12.5 mclk_in = ~mclk_in;
   end
   // hang guard, far above the roughly 1100 cycles the run needs
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         finish_test();
      end
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // writes take effect at the next edge; model follows the mask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      reg_req_in = '{1'b1, a, d};
      @(negedge mclk_in);
      reg_req_in.wr = 1'b0;
      if (a >= 8'h03 && a <= 8'h05)
         regs[a] = (a == 8'h03) ? d & 8'hFE : d;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge mclk_in);
      reg_raddr_in = a;
      @(negedge mclk_in);
      chk(reg_rdata_out, (a >= 8'h03 && a <= 8'h05) ?
         regs[a] : 8'h00);
   endtask
   // raise one raw line for k cycles, report first cycle it passed
   task automatic pulse(input int b, input int k, output int t);
      t = 99;
      for (int i = 0; i < 20; i++) begin
         @(negedge mclk_in);
         raw[b] = (i < k);
         if (filt[b] === 1'b1 && t == 99)
            t = i;
      end
   endtask
   // start one far-end transaction, report the cycle of any abort
   task automatic txn(input logic [7:0] l, output int t);
      t = 99;
      @(negedge mclk_in);
      go = 1'b1;
      lat = l;
      for (int i = 0; i < 60; i++) begin
         @(negedge mclk_in);
         go = 1'b0;
         if (cc_txn_abort_out === 1'b1)
            t = i;
      end
   endtask
   task automatic finish_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] a, d;
      int b, k;
      void'($urandom(18468));
      regs[3] = 8'hF0;
      regs[4] = 8'hFE;
      regs[5] = 8'h1E;
      repeat (12) @(negedge mclk_in);
      reset_n_in = 1'b1;
      for (int j = 2; j < 7; j++)
         rd(8'(j));
      // random traffic, unmapped 0x06 included
      for (int i = 0; i < 24; i++) begin
         a = 8'(3 + $urandom_range(3));
         d = 8'($urandom);
         if (a == 8'h04 && d[7:1] == 7'h00)
            d[7:1] = 7'h01;
         wr(a, d);
         rd(a);
         chk(backchan_crc_gen_on_out, regs[3][6]);
         chk(undriven_input_pull_dir_out, regs[3][5]);
      end
      // every mix of forward, ack and gate bits and address match; lock and partner random
      backchan_on_in = 1'b0;
      for (int i = 0; i < 64; i++) begin
         wr(8'h03, {4'hF, i[1], i[2], i[3], 1'b0});
         wr(8'h05, {i[4], regs[5][6:0]});
         i2c_txn_start_in = 1'b1;
         i2c_wr_req_in = 1'b1;
         i2c_addr_match_in = i[5];
         fwd_lock_in = 1'($urandom);
         protected_partner_in = 1'($urandom);
         raw[4] = 1'($urandom);
         pixel_in = PIXEL_W'($urandom);
         @(negedge mclk_in);
         chk(i2c_forward_out, i[4] | i[1] & i[5]);
         chk(i2c_wr_ack_out, i[2] | fwd_lock_in);
         chk(pixel_out, ((protected_partner_in | i[3]) & !raw[4]) ?
            '0 : pixel_in);
         chk(backchan_active_out, i[1] | i[4]);
         i2c_txn_start_in = 1'b0;
         i2c_wr_req_in = 1'b0;
      end
      // sync filters: one cycle short is dropped, the full width passes
      raw = 5'h00;
      wr(8'h05, 8'h1E);
      for (int j = 0; j < 6; j++) begin
         dual_lane_in = j[0];
         b = 2 + j / 2;
         k = (b == 3 && dual_lane_in) ? 4 : 2;
         pulse(b, k - 1, t1);
         chk(t1, 99);
         pulse(b, k, t1);
         chk(t1 < 99, 1'b1);
      end
      wr(8'h03, 8'hE0);
      pulse(4, 1, t1);
      chk(t1 < 99, 1'b1);
      // glitch depth 0xE: 50 ns dropped, 75 ns kept; SDA held behind
      pulse(1, 2, t1);
      chk(t1, 99);
      pulse(1, 3, t1);
      chk(t1 < 99, 1'b1);
      pulse(0, 8, t1);
      chk(t1 >= 5 && t1 <= 8, 1'b1);
      wr(8'h05, 8'h10);
      pulse(1, 1, t1);
      chk(t1 < 99, 1'b1);
      // watchdog: abort after field units, none when switched off
      for (int f = 1; f < 4; f++) begin
         wr(8'h04, 8'(f << 1));
         txn(8'h28, t1);
         chk(t1 >= f * UNIT && t1 <= f * UNIT + 3, 1'b1);
      end
      txn(8'h02, t1);
      chk(t1, 99);
      wr(8'h04, 8'h03);
      txn(8'h28, t1);
      chk(t1, 99);
      // mid-run reset: clear misc config, then expect reset values back
      wr(8'h03, 8'h00);
      reset_n_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      chk(backchan_active_out, 1'b1);
      chk(backchan_crc_gen_on_out, 1'b1);
      chk(undriven_input_pull_dir_out, 1'b1);
      reset_n_in = 1'b1;
      regs[3] = MISC_CFG_RESET;
      regs[4] = TIMEOUT_CTL_RESET;
      regs[5] = FWD_FILT_RESET;
      for (int j = 3; j < 6; j++)
         rd(8'(j));
      finish_test();
   end
endmodule // tb
